// ==== tsmc_pkg.sv ====
// package for the touch scan and mode control block
// assumes a single 125 MHz clock and plain configuration ports
package tsmc_pkg;

  // --------------------------------------------------------------
  // clock and timing
  // --------------------------------------------------------------
  localparam int unsigned TSMC_CLK_HZ = 125000000;
  localparam int unsigned TSMC_MS_PER_S = 1000;
  localparam int unsigned TSMC_MIN_PERIOD_MS = 15;
  localparam int unsigned TSMC_ACTIVE_PERIOD_MS = 30;
  localparam int unsigned TSMC_DOZE_PERIOD_MS = 195;
  localparam int unsigned TSMC_BUZZ_MS = 30;
  localparam int unsigned TSMC_MS_CYCLES = TSMC_CLK_HZ / TSMC_MS_PER_S;
  localparam int unsigned TSMC_PWM_HZ = 2000000;
  localparam int unsigned TSMC_PWM_DIV = TSMC_CLK_HZ / TSMC_PWM_HZ;
  localparam int unsigned TSMC_BUZZ_HZ = 4000;
  localparam int unsigned TSMC_BUZZ_HALF = TSMC_CLK_HZ / (2 * TSMC_BUZZ_HZ);

  // --------------------------------------------------------------
  // widths and reset values
  // --------------------------------------------------------------
  localparam int unsigned TSMC_NCH = 8;
  localparam int unsigned TSMC_PIN_AOI_A = 7;
  localparam int unsigned TSMC_PIN_AOI_B = 6;
  localparam int unsigned TSMC_PIN_BUZZ = 5;
  localparam logic [15:0] TSMC_RST_ACTIVE_MS = 16'h001E;
  localparam logic [15:0] TSMC_RST_DOZE_MS = 16'h00C3;
  localparam logic [15:0] TSMC_RST_IDLE_PERIODS = 16'h0000;
  localparam logic [7:0] TSMC_RST_FADE_END = 8'hFF;

  // --------------------------------------------------------------
  // enumerations
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    TSMC_CMD_AUTO = 2'h0,
    TSMC_CMD_ACTIVE = 2'h1,
    TSMC_CMD_DOZE = 2'h2,
    TSMC_CMD_SLEEP = 2'h3
  } tsmc_cmd_t;

  typedef enum logic [1:0] {
    TSMC_PIN_FADE = 2'h0,
    TSMC_PIN_DIRECT = 2'h1,
    TSMC_PIN_SPECIAL = 2'h2,
    TSMC_PIN_OFF = 2'h3
  } tsmc_pinmode_t;

  typedef enum logic [4:0] {
    TSMC_ST_BOOT = 5'b00001,
    TSMC_ST_SENSE = 5'b00010,
    TSMC_ST_PROC = 5'b00100,
    TSMC_ST_TIMER = 5'b01000,
    TSMC_ST_SLEEP = 5'b10000
  } tsmc_state_t;

  typedef enum logic [2:0] {
    TSMC_MODE_ACTIVE = 3'b001,
    TSMC_MODE_DOZE = 3'b010,
    TSMC_MODE_SLEEP = 3'b100
  } tsmc_mode_t;

  // --------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------
  typedef struct packed {
    logic [15:0] active_ms;
    logic [15:0] doze_ms;
    logic [15:0] idle_periods;
    logic [7:0] sense_enable;
    logic auto_light;
    logic fade_log;
    logic [7:0] fade_step_ms;
    logic [7:0] fade_start;
    logic [7:0] fade_end;
    logic buzz_enable;
    logic aoi_short_period;
    logic [7:0] aoi_idle_level;
  } tsmc_cfg_t;

  typedef struct packed {
    logic [7:0] level;
    logic to_a;
    logic to_b;
  } tsmc_aoi_map_t;

endpackage : tsmc_pkg

// ==== tsmc_pwm_chan.sv ====
// one pwm generator with fade engine for a general purpose pin
// assumes pwm_tick and step_tick are one-cycle enables from the top
`timescale 1ns/100ps
module tsmc_pwm_chan
  import tsmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pwm_tick,
  input wire logic step_tick,
  input wire logic [7:0] pwm_count,
  input wire logic fade_on,
  input wire logic fade_log,
  input wire logic [7:0] fade_start,
  input wire logic [7:0] fade_end,
  input wire logic use_direct,
  input wire logic [7:0] direct_width,
  output logic pwm_out
);

  // ----------------------------------------------------------------
  // fade level
  // ----------------------------------------------------------------
  logic [7:0] level;
  logic [7:0] next_level;
  logic [7:0] width;
  logic next_pwm_out;

  always_comb begin
    next_level = level;
    if (step_tick) begin
      if (fade_on && level < fade_end) begin
        if (fade_log) begin
          next_level = (fade_end - level > 8'(level >> 3) + 8'h01) ?
                       level + 8'(level >> 3) + 8'h01 : fade_end;
        end else begin
          next_level = level + 8'h01;
        end
      end else if (!fade_on && level > fade_start) begin
        if (fade_log) begin
          next_level = (level - fade_start > 8'(level >> 3) + 8'h01) ?
                       level - 8'(level >> 3) - 8'h01 : fade_start;
        end else begin
          next_level = level - 8'h01;
        end
      end else if (!fade_on && level < fade_start) begin
        next_level = fade_start;
      end
    end
  end

  // ----------------------------------------------------------------
  // 256 step comparator
  // ----------------------------------------------------------------
  always_comb begin
    width = use_direct ? direct_width : level;
    next_pwm_out = pwm_out;
    if (pwm_tick) begin
      next_pwm_out = (pwm_count < width) || (width == 8'hFF);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= 8'h00;
      pwm_out <= 1'b0;
    end else begin
      level <= next_level;
      pwm_out <= next_pwm_out;
    end
  end

endmodule : tsmc_pwm_chan

// ==== tsmc_core.sv ====
// scan sequencer, mode control and pin output control
// assumes touch results, nvm image and host writes arrive as synchronous ports
`timescale 1ns/100ps

// Functional notes
// - each scan period runs sensing, then processing, then a low-power wait.
// - sensing visits enabled inputs in ascending order from input zero.
// - processing evaluates results, then updates pins and host state.
// - timer phase idles in low power until the next period starts.
// - host programs period length; minimum fifteen milliseconds, over a second allowed.
// - pin intent, host state and alert assertion change only during processing; a host read releases alert unless processing asserts it in that same cycle.
// - alert line goes low when new touch or release data waits.
// - active mode uses short period, typically thirty milliseconds.
// - doze mode uses longer period, typically 195 milliseconds.
// - sleep stops scanning; any host access wakes the device.
// - inactivity timeout moves active to doze; configurable, zero disables.
// - a touch in doze returns the device to active mode.
// - host may force the operating mode; device obeys.
// - fading uses 256 step pwm, linear or log, selectable step and limits.
// - eight independent pwm generators, one per pin.
// - with auto light, touch fades mapped pin in, release fades out.
// - without auto light, host pin write starts autonomous fade.
// - direct mode outputs the host written pulse width; a width of 8'hFF holds the pin high for the whole period.
// - special mode drives level outputs on pins seven and six.
// - level output duty follows the touched button's configured level.
// - buzzer on pin five sounds about thirty milliseconds per touch.
// - boot loads nvm parameters when programmed; host may overwrite later.
module tsmc_core
  import tsmc_pkg::*;
#(
  parameter int unsigned MS_CYCLES = TSMC_MS_CYCLES
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic nvm_programmed,
  input wire logic nvm_valid,
  input wire tsmc_cfg_t nvm_cfg,
  input wire logic host_cfg_write,
  input wire tsmc_cfg_t host_cfg,
  input wire logic host_access,
  input wire logic host_read_done,
  input wire tsmc_cmd_t operating_mode_control,
  input wire tsmc_pinmode_t [7:0] pin_mode,
  input wire logic [7:0] host_pin_level,
  input wire logic [7:0][7:0] host_pwm_width,
  input wire logic [7:0][2:0] button_to_pin,
  input wire tsmc_aoi_map_t [7:0] aoi_map,
  output logic sense_start,
  output logic [2:0] sense_index,
  input wire logic sense_done,
  input wire logic [7:0] touch_result,
  output logic [7:0] touch_status,
  output logic host_alert_n,
  output tsmc_mode_t op_mode,
  output logic low_power,
  output logic boot_done,
  output logic [7:0] gpio_out
);

  // ----------------------------------------------------------------
  // configuration store
  // ----------------------------------------------------------------
  tsmc_cfg_t cfg;
  tsmc_cfg_t next_cfg;
  logic [15:0] period_ms;

  always_comb begin
    next_cfg = cfg;
    if (!boot_done && nvm_valid && nvm_programmed) begin
      next_cfg = nvm_cfg;
    end else if (host_cfg_write) begin
      next_cfg = host_cfg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= '{active_ms: TSMC_RST_ACTIVE_MS, doze_ms: TSMC_RST_DOZE_MS,
               idle_periods: TSMC_RST_IDLE_PERIODS, sense_enable: 8'hFF,
               auto_light: 1'b1, fade_log: 1'b0, fade_step_ms: 8'h01,
               fade_start: 8'h00, fade_end: TSMC_RST_FADE_END, buzz_enable: 1'b0,
               aoi_short_period: 1'b0, aoi_idle_level: 8'h00};
    end else begin
      cfg <= next_cfg;
    end
  end

  // ----------------------------------------------------------------
  // millisecond and pwm enables
  // ----------------------------------------------------------------
  logic [16:0] ms_div;
  logic [16:0] next_ms_div;
  logic ms_tick;
  logic [5:0] pwm_div;
  logic [5:0] next_pwm_div;
  logic pwm_tick;
  logic [7:0] pwm_count;
  logic [7:0] next_pwm_count;

  always_comb begin
    ms_tick = (ms_div == 17'(MS_CYCLES - 1));
    next_ms_div = ms_tick ? 17'h00000 : ms_div + 17'h00001;
    pwm_tick = (pwm_div == 6'(TSMC_PWM_DIV - 1));
    next_pwm_div = pwm_tick ? 6'h00 : pwm_div + 6'h01;
    next_pwm_count = pwm_count;
    if (pwm_tick) begin
      next_pwm_count = pwm_count + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_div <= 17'h00000;
      pwm_div <= 6'h00;
      pwm_count <= 8'h00;
    end else begin
      ms_div <= next_ms_div;
      pwm_div <= next_pwm_div;
      pwm_count <= next_pwm_count;
    end
  end

  // ----------------------------------------------------------------
  // scan sequencer and mode control
  // ----------------------------------------------------------------
  tsmc_state_t state;
  tsmc_state_t next_state;
  tsmc_mode_t next_op_mode;
  logic [15:0] ms_count;
  logic [15:0] next_ms_count;
  logic [15:0] idle_count;
  logic [15:0] next_idle_count;
  logic [2:0] next_sense_index;
  logic next_sense_start;
  logic [7:0] raw;
  logic [7:0] next_raw;
  logic [7:0] next_touch_status;
  logic next_host_alert_n;
  logic next_boot_done;
  logic [7:0] next_new_touch;

  always_comb begin
    period_ms = (op_mode == TSMC_MODE_DOZE) ? cfg.doze_ms : cfg.active_ms;
    if (period_ms < 16'(TSMC_MIN_PERIOD_MS)) begin
      period_ms = 16'(TSMC_MIN_PERIOD_MS);
    end
  end

  always_comb begin
    next_state = state;
    next_op_mode = op_mode;
    next_ms_count = ms_count;
    next_idle_count = idle_count;
    next_sense_index = sense_index;
    next_sense_start = 1'b0;
    next_raw = raw;
    next_touch_status = touch_status;
    next_host_alert_n = host_alert_n;
    next_boot_done = boot_done;
    next_new_touch = 8'h00;
    if (!host_alert_n && host_read_done) begin
      next_host_alert_n = 1'b1;
    end
    if (ms_tick && state != TSMC_ST_SLEEP) begin
      next_ms_count = ms_count + 16'h0001;
    end
    case (state)
      TSMC_ST_BOOT: begin
        if (nvm_valid || !nvm_programmed) begin
          next_boot_done = 1'b1;
          next_state = TSMC_ST_TIMER;
        end
      end
      TSMC_ST_SENSE: begin
        if (!cfg.sense_enable[sense_index]) begin
          next_raw[sense_index] = 1'b0;
          if (sense_index == 3'h7) begin
            next_state = TSMC_ST_PROC;
          end else begin
            next_sense_index = sense_index + 3'h1;
            next_sense_start = cfg.sense_enable[sense_index + 3'h1];
          end
        end else if (!sense_start && sense_done) begin
          next_raw[sense_index] = touch_result[sense_index];
          if (sense_index == 3'h7) begin
            next_state = TSMC_ST_PROC;
          end else begin
            next_sense_index = sense_index + 3'h1;
            next_sense_start = cfg.sense_enable[sense_index + 3'h1];
          end
        end
      end
      TSMC_ST_PROC: begin
        next_touch_status = raw & cfg.sense_enable;
        next_new_touch = raw & cfg.sense_enable & ~touch_status;
        if ((raw & cfg.sense_enable) != touch_status) begin
          next_host_alert_n = 1'b0;
        end
        if (|(raw & cfg.sense_enable)) begin
          next_idle_count = 16'h0000;
          if (op_mode == TSMC_MODE_DOZE && operating_mode_control == TSMC_CMD_AUTO) begin
            next_op_mode = TSMC_MODE_ACTIVE;
          end
        end else if (cfg.idle_periods != 16'h0000 && op_mode == TSMC_MODE_ACTIVE) begin
          next_idle_count = idle_count + 16'h0001;
          if (idle_count + 16'h0001 >= cfg.idle_periods && operating_mode_control == TSMC_CMD_AUTO) begin
            next_op_mode = TSMC_MODE_DOZE;
            next_idle_count = 16'h0000;
          end
        end
        next_state = TSMC_ST_TIMER;
      end
      TSMC_ST_TIMER: begin
        if (next_ms_count >= period_ms) begin
          next_ms_count = 16'h0000;
          next_sense_index = 3'h0;
          next_sense_start = cfg.sense_enable[0];
          next_state = TSMC_ST_SENSE;
        end
      end
      TSMC_ST_SLEEP: begin
        if (host_access) begin
          next_op_mode = TSMC_MODE_ACTIVE;
          next_ms_count = 16'h0000;
          next_state = TSMC_ST_TIMER;
        end
      end
      default: begin
        next_state = TSMC_ST_BOOT;
      end
    endcase
    if (boot_done) begin
      case (operating_mode_control)
        TSMC_CMD_ACTIVE: next_op_mode = TSMC_MODE_ACTIVE;
        TSMC_CMD_DOZE: next_op_mode = TSMC_MODE_DOZE;
        TSMC_CMD_SLEEP: begin
          if (state == TSMC_ST_TIMER && !host_access) begin
            next_op_mode = TSMC_MODE_SLEEP;
            next_sense_start = 1'b0;
            next_state = TSMC_ST_SLEEP;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= TSMC_ST_BOOT;
      op_mode <= TSMC_MODE_ACTIVE;
      ms_count <= 16'h0000;
      idle_count <= 16'h0000;
      sense_index <= 3'h0;
      sense_start <= 1'b0;
      raw <= 8'h00;
      touch_status <= 8'h00;
      host_alert_n <= 1'b1;
      boot_done <= 1'b0;
    end else begin
      state <= next_state;
      op_mode <= next_op_mode;
      ms_count <= next_ms_count;
      idle_count <= next_idle_count;
      sense_index <= next_sense_index;
      sense_start <= next_sense_start;
      raw <= next_raw;
      touch_status <= next_touch_status;
      host_alert_n <= next_host_alert_n;
      boot_done <= next_boot_done;
    end
  end

  assign low_power = (state == TSMC_ST_TIMER) || (state == TSMC_ST_SLEEP);

  // ----------------------------------------------------------------
  // pin intent latched in processing
  // ----------------------------------------------------------------
  logic [7:0] fade_on;
  logic [7:0] next_fade_on;
  logic [7:0] step_div;
  logic [7:0] next_step_div;
  logic step_tick;

  always_comb begin
    next_fade_on = fade_on;
    if (state == TSMC_ST_PROC) begin
      for (int p = 0; p < TSMC_NCH; p++) begin
        next_fade_on[p] = host_pin_level[p];
        if (cfg.auto_light) begin
          next_fade_on[p] = 1'b0;
          for (int b = 0; b < TSMC_NCH; b++) begin
            if (button_to_pin[b] == 3'(p) && raw[b] && cfg.sense_enable[b]) begin
              next_fade_on[p] = 1'b1;
            end
          end
        end
      end
    end
    step_tick = ms_tick && (step_div + 8'h01 >= cfg.fade_step_ms);
    next_step_div = step_div;
    if (ms_tick) begin
      next_step_div = step_tick ? 8'h00 : step_div + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fade_on <= 8'h00;
      step_div <= 8'h00;
    end else begin
      fade_on <= next_fade_on;
      step_div <= next_step_div;
    end
  end

  // ----------------------------------------------------------------
  // eight pwm generators
  // ----------------------------------------------------------------
  logic [7:0] chan_out;

  for (genvar g = 0; g < TSMC_NCH; g++) begin : g_chan
    tsmc_pwm_chan u_chan (
      .clk(clk),
      .rst_n(rst_n),
      .pwm_tick(pwm_tick),
      .step_tick(step_tick),
      .pwm_count(pwm_count),
      .fade_on(fade_on[g]),
      .fade_log(cfg.fade_log),
      .fade_start(cfg.fade_start),
      .fade_end(cfg.fade_end),
      .use_direct(pin_mode[g] == TSMC_PIN_DIRECT),
      .direct_width(host_pwm_width[g]),
      .pwm_out(chan_out[g])
    );
  end

  // ----------------------------------------------------------------
  // level outputs and buzzer
  // ----------------------------------------------------------------
  logic [7:0] aoi_a_level;
  logic [7:0] aoi_b_level;
  logic [7:0] next_aoi_a_level;
  logic [7:0] next_aoi_b_level;
  logic [7:0] aoi_cnt;
  logic aoi_a_out;
  logic aoi_b_out;
  logic [15:0] buzz_ms;
  logic [15:0] next_buzz_ms;
  logic [15:0] buzz_div;
  logic [15:0] next_buzz_div;
  logic buzz_wave;
  logic next_buzz_wave;
  logic [7:0] next_gpio_out;

  always_comb begin
    next_aoi_a_level = aoi_a_level;
    next_aoi_b_level = aoi_b_level;
    if (state == TSMC_ST_PROC) begin
      next_aoi_a_level = cfg.aoi_idle_level;
      next_aoi_b_level = cfg.aoi_idle_level;
      for (int b = TSMC_NCH - 1; b >= 0; b--) begin
        if (raw[b] && cfg.sense_enable[b] && aoi_map[b].to_a) begin
          next_aoi_a_level = aoi_map[b].level;
        end
        if (raw[b] && cfg.sense_enable[b] && aoi_map[b].to_b) begin
          next_aoi_b_level = aoi_map[b].level;
        end
      end
    end
    aoi_cnt = cfg.aoi_short_period ? {2'b00, pwm_count[5:0]} : pwm_count;
    aoi_a_out = aoi_cnt < aoi_a_level;
    aoi_b_out = aoi_cnt < aoi_b_level;
    next_buzz_ms = buzz_ms;
    next_buzz_div = buzz_div;
    next_buzz_wave = buzz_wave;
    if (state == TSMC_ST_PROC && cfg.buzz_enable && |next_new_touch) begin
      next_buzz_ms = 16'(TSMC_BUZZ_MS);
    end else if (ms_tick && buzz_ms != 16'h0000) begin
      next_buzz_ms = buzz_ms - 16'h0001;
    end
    if (buzz_ms == 16'h0000) begin
      next_buzz_div = 16'h0000;
      next_buzz_wave = 1'b0;
    end else if (buzz_div == 16'(TSMC_BUZZ_HALF - 1)) begin
      next_buzz_div = 16'h0000;
      next_buzz_wave = !buzz_wave;
    end else begin
      next_buzz_div = buzz_div + 16'h0001;
    end
    for (int p = 0; p < TSMC_NCH; p++) begin
      case (pin_mode[p])
        TSMC_PIN_SPECIAL: next_gpio_out[p] = 1'b0;
        TSMC_PIN_OFF: next_gpio_out[p] = 1'b0;
        default: next_gpio_out[p] = chan_out[p];
      endcase
    end
    if (pin_mode[TSMC_PIN_AOI_A] == TSMC_PIN_SPECIAL) begin
      next_gpio_out[TSMC_PIN_AOI_A] = aoi_a_out;
    end
    if (pin_mode[TSMC_PIN_AOI_B] == TSMC_PIN_SPECIAL) begin
      next_gpio_out[TSMC_PIN_AOI_B] = aoi_b_out;
    end
    if (pin_mode[TSMC_PIN_BUZZ] == TSMC_PIN_SPECIAL) begin
      next_gpio_out[TSMC_PIN_BUZZ] = buzz_wave;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aoi_a_level <= 8'h00;
      aoi_b_level <= 8'h00;
      buzz_ms <= 16'h0000;
      buzz_div <= 16'h0000;
      buzz_wave <= 1'b0;
      gpio_out <= 8'h00;
    end else begin
      aoi_a_level <= next_aoi_a_level;
      aoi_b_level <= next_aoi_b_level;
      buzz_ms <= next_buzz_ms;
      buzz_div <= next_buzz_div;
      buzz_wave <= next_buzz_wave;
      gpio_out <= next_gpio_out;
    end
  end

endmodule : tsmc_core

// ==== tsmc_core_sva.sv ====
// checker for scan sequencing, alert and mode control
// assumes it is bound onto tsmc_core
`timescale 1ns/100ps
module tsmc_core_sva
  import tsmc_pkg::*;
#(
  parameter int unsigned MS_CYCLES = TSMC_MS_CYCLES
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic host_access,
  input wire logic host_read_done,
  input wire logic sense_start,
  input wire logic [2:0] sense_index,
  input wire logic [7:0] touch_status,
  input wire logic host_alert_n,
  input wire tsmc_mode_t op_mode,
  input wire logic low_power,
  input wire logic boot_done
);
  logic new_scan;
  logic next_new_scan;
  logic [2:0] prev_idx;
  logic [2:0] next_prev_idx;
  logic [31:0] lp_cnt;
  logic [31:0] next_lp_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // track scan boundaries and scan length
  always_comb begin
    next_new_scan = new_scan;
    next_prev_idx = prev_idx;
    next_lp_cnt = lp_cnt + 32'h1;
    if (low_power) begin
      next_new_scan = 1'b1;
    end
    if (sense_start) begin
      next_new_scan = 1'b0;
      next_prev_idx = sense_index;
      if (new_scan) begin
        next_lp_cnt = 32'h0;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      new_scan <= 1'b1;
      prev_idx <= 3'h0;
      lp_cnt <= 32'h0;
    end else begin
      new_scan <= next_new_scan;
      prev_idx <= next_prev_idx;
      lp_cnt <= next_lp_cnt;
    end
  end
  a_start_pulse: assert property (sense_start |=> !sense_start)
    else $error("sense start longer than one cycle");
  a_index_ascend: assert property (sense_start && !new_scan |-> sense_index > prev_idx)
    else $error("sense order not ascending");
  a_timer_quiet: assert property (low_power |-> !sense_start)
    else $error("sensing during low power");
  a_period_min: assert property (sense_start && new_scan |-> lp_cnt >= 15 * MS_CYCLES - 2)
    else $error("scan period too short");
  a_status_proc: assert property (!$stable(touch_status) |-> low_power && !$past(low_power, 2))
    else $error("status changed outside processing");
  a_alert_proc: assert property ($fell(host_alert_n) |-> low_power && !$past(low_power, 2))
    else $error("alert raised outside processing");
  a_alert_clear: assert property (host_read_done && low_power |=> host_alert_n)
    else $error("alert not released by read");
  a_sleep_idle: assert property (op_mode == TSMC_MODE_SLEEP |-> !sense_start)
    else $error("sensing in sleep");
  a_sleep_wake: assert property (op_mode == TSMC_MODE_SLEEP && host_access |-> ##[1:2] op_mode == TSMC_MODE_ACTIVE)
    else $error("no wake on host access");
  a_boot_hold: assert property (boot_done |=> boot_done)
    else $error("boot done dropped");
  a_boot_first: assert property (!boot_done |-> !sense_start)
    else $error("sensing before boot");
endmodule : tsmc_core_sva
bind tsmc_core tsmc_core_sva #(.MS_CYCLES(MS_CYCLES)) u_sva (.clk(clk), .rst_n(rst_n), .host_access(host_access),
  .host_read_done(host_read_done), .sense_start(sense_start), .sense_index(sense_index), .touch_status(touch_status),
  .host_alert_n(host_alert_n), .op_mode(op_mode), .low_power(low_power), .boot_done(boot_done));

// ==== tsmc_sense_model.sv ====
// sensor front end answering each measurement request
// assumes sense_start is a one-cycle pulse
`timescale 1ns/100ps
module tsmc_sense_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sense_start,
  input wire logic slow,
  input wire logic [7:0] touch_mask,
  output logic sense_done,
  output logic [7:0] touch_result
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  always_comb begin
    next_cnt = cnt;
    if (sense_start) begin
      next_cnt = slow ? 4'h9 : 4'h2;
    end else if (cnt != 4'h0) begin
      next_cnt = cnt - 4'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
    end else begin
      cnt <= next_cnt;
    end
  end
  // result valid only with done, inverted otherwise
  assign sense_done = cnt == 4'h1;
  assign touch_result = sense_done ? touch_mask : ~touch_mask;
endmodule : tsmc_sense_model

// ==== test_touch_scan_mode_control.sv ====
// testbench for tsmc_core with a behavioural sensor front end
// assumes MS_CYCLES shortened to 10 cycles per millisecond
`timescale 1ns/100ps
module test_touch_scan_mode_control
  import tsmc_pkg::*;
;
  localparam int MS = 10;
  logic clk, rst_n, host_cfg_write, host_access, host_read_done, slow;
  logic sense_start, sense_done, host_alert_n, low_power, boot_done;
  logic [7:0] mask, touch_result, touch_status, gpio_out;
  logic [2:0] sense_index;
  logic [7:0][7:0] pwidth;
  tsmc_pinmode_t [7:0] pmode;
  tsmc_cfg_t cfg, hcfg;
  tsmc_cmd_t ctl;
  tsmc_mode_t op_mode;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int hi0, hi1;
  tsmc_core #(.MS_CYCLES(MS)) dut (.clk(clk), .rst_n(rst_n), .nvm_programmed(1'b1), .nvm_valid(1'b1),
    .nvm_cfg(cfg), .host_cfg_write(host_cfg_write), .host_cfg(hcfg), .host_access(host_access),
    .host_read_done(host_read_done), .operating_mode_control(ctl), .pin_mode(pmode), .host_pin_level(8'h00),
    .host_pwm_width(pwidth), .button_to_pin('0), .aoi_map('0), .sense_start(sense_start),
    .sense_index(sense_index), .sense_done(sense_done), .touch_result(touch_result), .touch_status(touch_status),
    .host_alert_n(host_alert_n), .op_mode(op_mode), .low_power(low_power), .boot_done(boot_done),
    .gpio_out(gpio_out));
  tsmc_sense_model u_sense (.clk(clk), .rst_n(rst_n), .sense_start(sense_start), .slow(slow),
    .touch_mask(mask), .sense_done(sense_done), .touch_result(touch_result));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task end_of_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic wait_scan();
    int k = 0;
    while (!sense_start && k < 5000) begin
      @(negedge clk);
      k++;
    end
    while (!low_power && k < 5000) begin
      @(negedge clk);
      k++;
    end
    check("scan wait", k < 5000, 1);
    repeat (2) @(negedge clk);
  endtask : wait_scan
  task automatic chk_len(input string name, input int ms);
    int n;
    wait_scan();
    n = 2;
    while (low_power && n < 5000) begin
      @(negedge clk);
      n++;
    end
    while (!low_power && n < 5000) begin
      @(negedge clk);
      n++;
    end
    check(name, n, ms * MS);
  endtask : chk_len
  initial begin
    rst_n = 1'b0;
    {host_cfg_write, host_access, host_read_done, slow} = 4'h0;
    mask = 8'h00;
    ctl = TSMC_CMD_AUTO;
    pmode = {8{TSMC_PIN_OFF}};
    pwidth = '0;
    cfg = '{16'h000F, 16'h0014, 16'h0002, 8'hFF, 1'b0, 1'b0, 8'h01, 8'h00, 8'hFF, 1'b0, 1'b0, 8'h00};
    hcfg = cfg;
    hcfg.active_ms = 16'h0010;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    check("boot_done", boot_done, 1);
    check("op_mode", op_mode, TSMC_MODE_ACTIVE);
    check("host_alert_n", host_alert_n, 1);
    $display("test boot done");
    mask = 8'h05;
    slow = 1'b1;
    wait_scan();
    check("touch_status", touch_status, 8'h05);
    check("host_alert_n", host_alert_n, 0);
    host_read_done = 1'b1;
    @(negedge clk);
    host_read_done = 1'b0;
    @(negedge clk);
    check("host_alert_n", host_alert_n, 1);
    $display("test report done");
    slow = 1'b0;
    chk_len("active timer", 15);
    host_cfg_write = 1'b1;
    @(negedge clk);
    host_cfg_write = 1'b0;
    chk_len("host timer", 16);
    $display("test period done");
    mask = 8'h00;
    repeat (4) wait_scan();
    check("op_mode", op_mode, TSMC_MODE_DOZE);
    chk_len("doze timer", 20);
    mask = 8'h80;
    wait_scan();
    check("op_mode", op_mode, TSMC_MODE_ACTIVE);
    $display("test modes done");
    ctl = TSMC_CMD_DOZE;
    repeat (2) wait_scan();
    check("op_mode", op_mode, TSMC_MODE_DOZE);
    ctl = TSMC_CMD_SLEEP;
    repeat (300) @(negedge clk);
    check("op_mode", op_mode, TSMC_MODE_SLEEP);
    ctl = TSMC_CMD_AUTO;
    host_access = 1'b1;
    @(negedge clk);
    host_access = 1'b0;
    repeat (2) @(negedge clk);
    check("op_mode", op_mode, TSMC_MODE_ACTIVE);
    $display("test force done");
    pmode[0] = TSMC_PIN_DIRECT;
    pmode[1] = TSMC_PIN_DIRECT;
    pwidth[0] = 8'h40;
    pwidth[1] = 8'hC0;
    wait_scan();
    {hi0, hi1} = '0;
    repeat (256 * TSMC_PWM_DIV) begin
      @(negedge clk);
      hi0 += int'(gpio_out[0]);
      hi1 += int'(gpio_out[1]);
    end
    check("pwm0 high", hi0, 64 * TSMC_PWM_DIV);
    check("pwm1 high", hi1, 192 * TSMC_PWM_DIV);
    $display("test pwm done");
    end_of_test();
  end
endmodule : test_touch_scan_mode_control
